/* File: cxt_baud_gate.sv */
// shared constants and the baud-domain warm-up counter
`timescale 1ns/10ps

package cxt_pkg;
   // ---------------------------------------------------------------
   // system clock and counter sizes
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int CNT_W = 16;
   typedef logic [CNT_W-1:0] cxt_cnt_t;
   localparam cxt_cnt_t CNT_ZERO = 16'h0000;
   localparam cxt_cnt_t CNT_ONE = 16'h0001;

   // least time in ns to whole clk cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // ---------------------------------------------------------------
   // bus waveform timing (20 kbps bit = 50000 ns)
   // ---------------------------------------------------------------
   localparam int LOW_ONE_NS = 12500;      // short low pulse, bit 1
   localparam int LOW_ZERO_NS = 25000;     // long low pulse, bit 0
   localparam int SAMPLE_NS = 18750;       // decode decision point
   localparam int CLKOUT_LOW_NS = 25000;   // recovered clock low phase
   localparam cxt_cnt_t LOW_ONE_CYC = cxt_cnt_t'(cyc_up(LOW_ONE_NS));
   localparam cxt_cnt_t LOW_ZERO_CYC = cxt_cnt_t'(cyc_up(LOW_ZERO_NS));
   localparam cxt_cnt_t SAMPLE_CYC = cxt_cnt_t'(cyc_up(SAMPLE_NS));
   localparam cxt_cnt_t CLKOUT_LOW_CYC = cxt_cnt_t'(cyc_up(CLKOUT_LOW_NS));

   // ---------------------------------------------------------------
   // mode timing
   // ---------------------------------------------------------------
   localparam int MODE_CHG_NS = 100000;
   localparam int SLEEP_WAIT_NS = 100000;  // kept by the controller
   localparam int BUS_ERR_NS = 1000000;    // bus stuck low limit
   localparam int MODE_CHG_DEF_CYC = cyc_up(MODE_CHG_NS);
   localparam int BUS_ERR_DEF_CYC = cyc_up(BUS_ERR_NS);

   // ---------------------------------------------------------------
   // baud warm-up and synchroniser layout
   // ---------------------------------------------------------------
   localparam int BAUD_CNT_W = 6;
   localparam logic [BAUD_CNT_W-1:0] BAUD_WARMUP = 6'h21;  // 33 periods
   localparam logic [BAUD_CNT_W-1:0] BAUD_ZERO = 6'h00;
   localparam logic [BAUD_CNT_W-1:0] BAUD_ONE = 6'h01;
   localparam int SYN_W = 8;
   localparam int SYN_ROLE = 0;
   localparam int SYN_SLEEP_CONTROL_N = 1;
   localparam int SYN_TXD = 2;
   localparam int SYN_WAKE = 3;
   localparam int SYN_THERM = 4;
   localparam int SYN_CLKP = 5;
   localparam int SYN_BUS = 6;
   localparam int SYN_READY = 7;
   localparam logic [SYN_W-1:0] SYN_IDLE = 8'h64;  // pins at rest
   localparam logic PIN_LOW = 1'h0;

   typedef enum logic [1:0] {
      CXT_SLEEP = 2'b00,
      CXT_STANDBY = 2'b01,
      CXT_NORMAL = 2'b10
   } cxt_mode_t;
endpackage

module cxt_baud_gate
   import cxt_pkg::*;
(
   input wire logic baud_clk,
   input wire logic rst,
   input wire logic enable,
   output logic ready
);
   logic rst_s1;
   logic rst_s2;
   logic en_s1;
   logic en_s2;
   logic [BAUD_CNT_W-1:0] cnt;

   // bring reset into the baud domain
   always_ff @(posedge baud_clk) begin
      rst_s1 <= rst;
      rst_s2 <= rst_s1;
   end

   // enable synchroniser, cleared at once: baud clock may be stopped
   always_ff @(posedge baud_clk or negedge enable) begin
      if (!enable) begin
         en_s1 <= 1'h0;
         en_s2 <= 1'h0;
      end else begin
         en_s1 <= 1'h1;
         en_s2 <= en_s1;
      end
   end

   // count baud periods after enable, ready on the 33rd
   always_ff @(posedge baud_clk or negedge enable) begin
      if (!enable) begin
         cnt <= BAUD_ZERO;
         ready <= 1'h0;
      end else if (rst_s2 || !en_s2) begin
         cnt <= BAUD_ZERO;
         ready <= 1'h0;
      end else if (cnt != BAUD_WARMUP) begin
         cnt <= cnt + BAUD_ONE;
         if (cnt == BAUD_WARMUP - BAUD_ONE) begin
            ready <= 1'h1;
         end
      end
   end

   property p_warmup;
      @(posedge baud_clk) disable iff (rst_s2)
      ready |-> cnt == BAUD_WARMUP;
   endproperty
   a_warmup: assert property (p_warmup)
      else $error("baud ready before 33 periods");

   property p_warmup_drop;
      @(posedge baud_clk) disable iff (rst_s2)
      !en_s2 |=> !ready && cnt == BAUD_ZERO;
   endproperty
   a_warmup_drop: assert property (p_warmup_drop)
      else $error("baud ready held without enable");

   c_warmup: cover property (@(posedge baud_clk) $rose(ready));
endmodule

/* File: cxt_ctrl_model.sv */
// controller model: baud clock source and uart framing on txd and rxd
`timescale 1ns/10ps

module cxt_ctrl_model
#(
   parameter int PER = 1200
)
(
   input wire logic clk,
   input wire logic rxd_line,
   output logic clk_drv,
   output logic txd
);
   // clock pin released high and line idle high at rest
   initial begin
      clk_drv = 1'h1;
      txd = 1'h1;
   end

   // one baud period per bit, txd settled before the clock falls
   task automatic send_bits(input logic [9:0] bits, input int n,
                            output logic [9:0] got);
      got = 10'h000;
      for (int i = 0; i < n; i++) begin
         @(posedge clk) txd <= bits[i];
         repeat (100) @(posedge clk);
         clk_drv <= 1'h0;
         repeat (PER / 2) @(posedge clk);
         clk_drv <= 1'h1;
         repeat (PER / 2 - 300) @(posedge clk);
         got[i] = rxd_line;
         repeat (199) @(posedge clk);
      end
      // back to idle high, clock left high
      @(posedge clk) txd <= 1'h1;
   endtask
endmodule

/* File: cxt_transceiver.sv */
// mode control, role control and bus coding of the single-wire transceiver
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps

module cxt_transceiver
   import cxt_pkg::*;
#(
   parameter int MODE_CHG_CYC = MODE_CHG_DEF_CYC,
   parameter int BUS_ERR_CYC = BUS_ERR_DEF_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic role_select,
   input wire logic sleep_control_n,
   input wire logic txd,
   input wire logic local_wake,
   input wire logic thermal_shutdown,
   input wire logic clk_pin_i,
   output logic clk_pin_o,
   output logic clk_pin_oe,
   input wire logic bus_i,
   output logic bus_o,
   output logic bus_oe,
   output logic rxd_o,
   output logic rxd_oe,
   output cxt_mode_t mode
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   localparam cxt_cnt_t MC_LIM = cxt_cnt_t'(MODE_CHG_CYC - 1);
   localparam cxt_cnt_t ERR_LIM = cxt_cnt_t'(BUS_ERR_CYC - 1);

   logic [SYN_W-1:0] syn_raw;
   logic [SYN_W-1:0] syn_s1;
   logic [SYN_W-1:0] syn_s2;
   logic role_slave;
   logic sleep_control_n_s;
   logic txd_s;
   logic wake_s;
   logic therm_s;
   logic clkp_s;
   logic bus_s;
   logic ready_s;
   logic clkp_prev;
   logic bus_prev;
   logic therm_prev;
   logic baud_fall;
   logic bus_fall;
   logic baud_ready;
   logic gate_en;
   logic gate_seen_low;
   logic bus_live;
   cxt_mode_t next_mode;
   cxt_cnt_t mc_cnt;
   logic mc_run;
   logic wake_held;
   cxt_cnt_t err_cnt;
   logic bus_err;
   logic tx_lock;
   logic tx_ok;
   logic start_m;
   logic start_s;
   logic drv;
   cxt_cnt_t drv_cnt;
   cxt_cnt_t drv_len;
   logic rx_run;
   cxt_cnt_t rx_cnt;
   logic rx_sample;
   cxt_cnt_t clko_cnt;

   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   // all asynchronous levels gathered into one vector
   assign syn_raw[SYN_ROLE] = role_select;
   assign syn_raw[SYN_SLEEP_CONTROL_N] = sleep_control_n;
   assign syn_raw[SYN_TXD] = txd;
   assign syn_raw[SYN_WAKE] = local_wake;
   assign syn_raw[SYN_THERM] = thermal_shutdown;
   assign syn_raw[SYN_CLKP] = clk_pin_i;
   assign syn_raw[SYN_BUS] = bus_i;
   assign syn_raw[SYN_READY] = baud_ready;

   // two flip-flops per input, first stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         syn_s1 <= SYN_IDLE;
         syn_s2 <= SYN_IDLE;
      end else if (ce) begin
         syn_s1 <= syn_raw;
         syn_s2 <= syn_s1;
      end
   end

   assign role_slave = syn_s2[SYN_ROLE];
   assign sleep_control_n_s = syn_s2[SYN_SLEEP_CONTROL_N];
   assign txd_s = syn_s2[SYN_TXD];
   assign wake_s = syn_s2[SYN_WAKE];
   assign therm_s = syn_s2[SYN_THERM];
   assign clkp_s = syn_s2[SYN_CLKP];
   assign bus_s = syn_s2[SYN_BUS];
   assign ready_s = syn_s2[SYN_READY];

   // previous values for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         clkp_prev <= SYN_IDLE[SYN_CLKP];
         bus_prev <= SYN_IDLE[SYN_BUS];
         therm_prev <= SYN_IDLE[SYN_THERM];
      end else if (ce) begin
         clkp_prev <= clkp_s;
         bus_prev <= bus_s;
         therm_prev <= therm_s;
      end
   end

   assign baud_fall = clkp_prev && !clkp_s;
   assign bus_fall = bus_prev && !bus_s;

   // ---------------------------------------------------------------
   // baud-domain warm-up before the master drives the bus
   // ---------------------------------------------------------------
   // master role in normal, registered so the gate clear is glitch free
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_en <= 1'h0;
      end else if (ce) begin
         gate_en <= mode == CXT_NORMAL && !role_slave;
      end
   end

   cxt_baud_gate cxt_baud_gate_inst (
      .baud_clk(clk_pin_i),
      .rst(rst),
      .enable(gate_en),
      .ready(baud_ready)
   );

   // ready only counts once it was seen low in this normal stay
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_seen_low <= 1'h0;
      end else if (ce) begin
         if (mode != CXT_NORMAL) begin
            gate_seen_low <= 1'h0;
         end else if (!ready_s) begin
            gate_seen_low <= 1'h1;
         end
      end
   end

   assign bus_live = gate_seen_low && ready_s;

   // ---------------------------------------------------------------
   // mode state machine
   // ---------------------------------------------------------------
   assign mc_run = (mode == CXT_SLEEP && (wake_s || !bus_s))
      || mode == CXT_STANDBY;
   assign wake_held = mode == CXT_SLEEP && mc_run && mc_cnt == MC_LIM;
   assign bus_err = mode != CXT_SLEEP && !bus_s && err_cnt == ERR_LIM;

   // next mode from pins, wake factors and bus error
   always_comb begin
      next_mode = mode;
      case (mode)
         CXT_SLEEP: begin
            if (sleep_control_n_s || wake_held) begin
               next_mode = CXT_STANDBY;
            end
         end
         CXT_STANDBY: begin
            if (bus_err) begin
               next_mode = CXT_SLEEP;
            end else if (mc_cnt == MC_LIM && sleep_control_n_s) begin
               next_mode = CXT_NORMAL;
            end
         end
         CXT_NORMAL: begin
            if (!sleep_control_n_s || bus_err) begin
               next_mode = CXT_SLEEP;
            end
         end
         default: begin
            next_mode = CXT_SLEEP;
         end
      endcase
   end

   // mode register, sleep after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= CXT_SLEEP;
      end else if (ce) begin
         mode <= next_mode;
      end
   end

   // wake hold and standby dwell counter
   always_ff @(posedge clk) begin
      if (rst) begin
         mc_cnt <= CNT_ZERO;
      end else if (ce) begin
         if (next_mode != mode || !mc_run) begin
            mc_cnt <= CNT_ZERO;
         end else if (mc_cnt != MC_LIM) begin
            mc_cnt <= mc_cnt + CNT_ONE;
         end
      end
   end

   // bus stuck-low counter for error detection
   always_ff @(posedge clk) begin
      if (rst) begin
         err_cnt <= CNT_ZERO;
      end else if (ce) begin
         if (mode == CXT_SLEEP || bus_s) begin
            err_cnt <= CNT_ZERO;
         end else if (err_cnt != ERR_LIM) begin
            err_cnt <= err_cnt + CNT_ONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit lock after thermal release
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_lock <= 1'h0;
      end else if (ce) begin
         if (therm_prev && !therm_s && !txd_s) begin
            tx_lock <= 1'h1;
         end else if (txd_s) begin
            tx_lock <= 1'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit encoder
   // ---------------------------------------------------------------
   assign tx_ok = mode == CXT_NORMAL && sleep_control_n_s && !therm_s && !tx_lock;
   assign start_m = !role_slave && tx_ok && bus_live && baud_fall;
   assign start_s = role_slave && tx_ok && bus_fall && !txd_s;

   // bit-wise pulse-width coding, one bit per baud period
   always_ff @(posedge clk) begin
      if (rst) begin
         drv <= 1'h0;
         drv_cnt <= CNT_ZERO;
         drv_len <= CNT_ZERO;
      end else if (ce) begin
         if (role_slave && mode == CXT_SLEEP) begin
            drv <= !txd_s;  // slave wake pulse, not encoded
            drv_cnt <= CNT_ZERO;
         end else if (!tx_ok) begin
            drv <= 1'h0;
         end else if (start_m) begin
            drv <= 1'h1;
            drv_cnt <= CNT_ZERO;
            drv_len <= txd_s ? LOW_ONE_CYC : LOW_ZERO_CYC;
         end else if (start_s) begin
            drv <= 1'h1;
            drv_cnt <= CNT_ZERO;
            drv_len <= LOW_ZERO_CYC;
         end else if (drv) begin
            drv_cnt <= drv_cnt + CNT_ONE;
            if (drv_cnt == drv_len - CNT_ONE) begin
               drv <= 1'h0;
            end
         end
      end
   end

   assign bus_oe = drv;
   assign bus_o = PIN_LOW;

   // ---------------------------------------------------------------
   // receive decoder and open-drain receive line
   // ---------------------------------------------------------------
   assign rx_sample = rx_run && rx_cnt == SAMPLE_CYC - CNT_ONE;

   // time each low pulse from its falling edge
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_run <= 1'h0;
         rx_cnt <= CNT_ZERO;
      end else if (ce) begin
         if (bus_fall) begin
            rx_run <= 1'h1;
            rx_cnt <= CNT_ZERO;
         end else if (rx_sample) begin
            rx_run <= 1'h0;
         end else if (rx_run) begin
            rx_cnt <= rx_cnt + CNT_ONE;
         end
      end
   end

   // bit 0 pulls the line low, bit 1 releases it
   always_ff @(posedge clk) begin
      if (rst) begin
         rxd_oe <= 1'h0;
      end else if (ce) begin
         if (mode == CXT_SLEEP && !role_slave) begin
            rxd_oe <= !bus_s;
         end else if (mode == CXT_NORMAL) begin
            if (rx_sample) begin
               rxd_oe <= !bus_s;
            end
         end else begin
            rxd_oe <= 1'h0;
         end
      end
   end

   assign rxd_o = PIN_LOW;

   // ---------------------------------------------------------------
   // clock pin: input in master role, output in slave role
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_pin_oe <= 1'h0;
         clko_cnt <= CNT_ZERO;
      end else if (ce) begin
         if (!role_slave || mode == CXT_STANDBY) begin
            clk_pin_oe <= 1'h0;
         end else if (mode == CXT_SLEEP) begin
            clk_pin_oe <= !bus_s;  // raw bus in sleep
         end else if (bus_fall) begin
            clk_pin_oe <= 1'h1;
            clko_cnt <= CNT_ZERO;
         end else if (clk_pin_oe) begin
            clko_cnt <= clko_cnt + CNT_ONE;
            if (clko_cnt == CLKOUT_LOW_CYC - CNT_ONE) begin
               clk_pin_oe <= 1'h0;
            end
         end
      end
   end

   assign clk_pin_o = PIN_LOW;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_reset_sleep;
      @(posedge clk) disable iff (1'h0)
      rst |=> mode == CXT_SLEEP && !bus_oe && !rxd_oe;
   endproperty
   a_reset_sleep: assert property (p_reset_sleep)
      else $error("not in sleep after reset");

   property p_master_sleep_quiet;
      mode == CXT_SLEEP && !role_slave |-> !bus_oe;
   endproperty
   a_master_sleep_quiet: assert property (p_master_sleep_quiet)
      else $error("master drives bus in sleep");

   property p_standby_hiz;
      ce && mode == CXT_STANDBY && $past(mode) == CXT_STANDBY
         |-> !bus_oe && !rxd_oe && !clk_pin_oe;
   endproperty
   a_standby_hiz: assert property (p_standby_hiz)
      else $error("pin driven in standby");

   property p_ctrl_drop;
      ce && mode == CXT_NORMAL && !sleep_control_n_s && txd_s
         |=> !bus_oe && mode == CXT_SLEEP;
   endproperty
   a_ctrl_drop: assert property (p_ctrl_drop)
      else $error("transmit not cut on control low");

   property p_master_clk_in;
      !role_slave |=> !clk_pin_oe;
   endproperty
   a_master_clk_in: assert property (p_master_clk_in)
      else $error("master drives clock pin");

   property p_sleep_pass;
      ce && mode == CXT_SLEEP && !role_slave |=> rxd_oe == !$past(bus_s);
   endproperty
   a_sleep_pass: assert property (p_sleep_pass)
      else $error("sleep receive not passed through");

   property p_standby_dwell;
      mode == CXT_NORMAL && $past(mode) == CXT_STANDBY
         |-> $past(mc_cnt) == MC_LIM;
   endproperty
   a_standby_dwell: assert property (p_standby_dwell)
      else $error("standby left early");

   property p_master_gate;
      ce && start_m |-> bus_live ##1 bus_oe;
   endproperty
   a_master_gate: assert property (p_master_gate)
      else $error("master drove before warm-up");

   property p_bus_err;
      ce && bus_err |=> mode == CXT_SLEEP;
   endproperty
   a_bus_err: assert property (p_bus_err)
      else $error("bus error did not give sleep");

   property p_one_len;
      ce && start_m && txd_s |=> drv_len == LOW_ONE_CYC && bus_oe;
   endproperty
   a_one_len: assert property (p_one_len)
      else $error("bit one pulse length wrong");

   property p_lock;
      tx_lock && mode == CXT_NORMAL |=> !bus_oe;
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked transmit drove bus");

   c_normal: cover property (mode == CXT_STANDBY ##1 mode == CXT_NORMAL);
   c_master_tx: cover property (start_m && !txd_s);
   c_slave_clk: cover property (role_slave && $rose(clk_pin_oe));
   c_bus_wake: cover property (wake_held && !bus_s);
endmodule

/* File: test_cxt_transceiver.sv */
// self-checking bench of the transceiver modes, coding and roles
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
   end \
end

module test_cxt_transceiver
   import cxt_pkg::*;
;
   // ---------------------------------------------------------------
   // pins, pull-ups and counters
   // ---------------------------------------------------------------
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic role_select = 1'h0;
   logic sleep_control_n = 1'h0;
   logic local_wake = 1'h0;
   logic thermal_shutdown = 1'h0;
   logic ext_low = 1'h0;
   wire clk_drv;
   wire txd;
   logic clk_pin_o, clk_pin_oe, bus_o, bus_oe, rxd_o, rxd_oe;
   cxt_mode_t mode;
   wire bus_line = !(bus_oe || ext_low); // pulled up
   wire clk_line = clk_drv && !clk_pin_oe;
   wire rxd_line = !rxd_oe;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int bw = 0;
   int cw = 0;
   int bq[$];
   int cq[$];
   logic [9:0] got;
   logic [9:0] frame = {1'h1, 8'h35, 1'h0};

   always #12.5 clk = ~clk;

   cxt_transceiver #(.MODE_CHG_CYC(20), .BUS_ERR_CYC(3000))
      cxt_transceiver_inst (.clk(clk), .rst(rst), .ce(1'h1),
      .role_select(role_select), .sleep_control_n(sleep_control_n),
      .txd(txd), .local_wake(local_wake),
      .thermal_shutdown(thermal_shutdown),
      .clk_pin_i(clk_line), .clk_pin_o(clk_pin_o),
      .clk_pin_oe(clk_pin_oe), .bus_i(bus_line), .bus_o(bus_o),
      .bus_oe(bus_oe), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .mode(mode));

   cxt_ctrl_model #(.PER(1200)) cxt_ctrl_model_inst (.clk(clk),
      .rxd_line(rxd_line), .clk_drv(clk_drv), .txd(txd));

   // pulse widths of bus and clock pin drives, and the hang limit
   always @(posedge clk) begin
      cyc++;
      if (bus_oe) bw++;
      else if (bw != 0) begin
         bq.push_back(bw);
         bw = 0;
      end
      if (clk_pin_oe) cw++;
      else if (cw != 0) begin
         cq.push_back(cw);
         cw = 0;
      end
      if (cyc == 80000) begin
         fail_count++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // wait edges, then let their updates land
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // master sleep: raw receive, short and held wake, bus error
   task automatic t_sleep_wake();
      int n;
      n = 0;
      `CHK("reset mode", CXT_SLEEP, mode)
      `CHK("reset bus", 1'h0, bus_oe)
      `CHK("drive lows", 3'h0, {clk_pin_o, bus_o, rxd_o})
      @(posedge clk) ext_low <= 1'h1;
      cy(4);
      `CHK("raw rxd", 1'h1, rxd_oe)
      `CHK("master clk pin", 1'h0, clk_pin_oe)
      cy(6);
      @(posedge clk) ext_low <= 1'h0;
      cy(30);
      `CHK("short wake", CXT_SLEEP, mode)
      @(posedge clk) local_wake <= 1'h1;
      cy(30);
      `CHK("local wake", CXT_STANDBY, mode)
      @(posedge clk) local_wake <= 1'h0;
      cy(30);
      `CHK("standby held", CXT_STANDBY, mode)
      @(posedge clk) ext_low <= 1'h1;
      cy(10);
      `CHK("standby rxd", 1'h0, rxd_oe)
      `CHK("standby bus", 1'h0, bus_oe)
      while (mode !== CXT_SLEEP && n < 3100) begin
         cy(1);
         n++;
      end
      @(posedge clk) ext_low <= 1'h0;
      `CHK("bus error", 1'h1, n > 2900 && n < 3050)
      $display("test sleep_wake done");
   endtask

   // master: held off by thermal, then locked until txd seen high
   task automatic t_thermal();
      bq.delete();
      @(posedge clk) thermal_shutdown <= 1'h1;
      fork
         cxt_ctrl_model_inst.send_bits(10'h005, 3, got);
         begin
            repeat (1250) @(posedge clk);
            thermal_shutdown <= 1'h0;
         end
      join
      `CHK("thermal pulses", 1, bq.size())
      `CHK("unlock width", 500, bq[0])
      $display("test thermal done");
   endtask

   // master: normal entry, warm-up, byte coding, sleep entry
   task automatic t_master();
      @(posedge clk) sleep_control_n <= 1'h1;
      cy(5);
      `CHK("to standby", CXT_STANDBY, mode)
      cy(10);
      `CHK("still standby", CXT_STANDBY, mode)
      cy(15);
      `CHK("to normal", CXT_NORMAL, mode)
      bq.delete();
      for (int i = 0; i < 3; i++)
         cxt_ctrl_model_inst.send_bits(10'h3FF, 10, got);
      cxt_ctrl_model_inst.send_bits(10'h3FF, 3, got);
      `CHK("warm-up pulses", 0, bq.size())
      cxt_ctrl_model_inst.send_bits(10'h3FF, 5, got);
      bq.delete();
      cxt_ctrl_model_inst.send_bits(frame, 10, got);
      cy(1);
      `CHK("rx frame", frame, got)
      `CHK("pulse count", 10, bq.size())
      for (int i = 0; i < 10; i++)
         `CHK("pulse width", frame[i] ? 500 : 1000, bq[i])
      t_thermal();
      cy(50);
      @(posedge clk) sleep_control_n <= 1'h0;
      cy(4);
      `CHK("sleep entry", CXT_SLEEP, mode)
      `CHK("tx cut", 1'h0, bus_oe)
      $display("test master done");
   endtask

   // slave: clock pin follows bus in sleep, released in standby,
   // recovered clock in normal
   task automatic t_slave();
      @(posedge clk) role_select <= 1'h1;
      cy(5);
      @(posedge clk) ext_low <= 1'h1;
      cy(5);
      `CHK("sleep clk out", 1'h1, clk_pin_oe)
      `CHK("slave rxd", 1'h0, rxd_oe)
      @(posedge clk) ext_low <= 1'h0;
      cy(5);
      `CHK("sleep clk rel", 1'h0, clk_pin_oe)
      @(posedge clk) sleep_control_n <= 1'h1;
      cy(5);
      @(posedge clk) ext_low <= 1'h1;
      cy(3);
      `CHK("standby clk", 1'h0, clk_pin_oe)
      @(posedge clk) ext_low <= 1'h0;
      cy(30);
      `CHK("slave normal", CXT_NORMAL, mode)
      cq.delete();
      @(posedge clk) ext_low <= 1'h1;
      cy(300);
      @(posedge clk) ext_low <= 1'h0;
      cy(1200);
      `CHK("clk pulses", 1, cq.size())
      `CHK("clk width", 1000, cq[0])
      $display("test slave done");
   endtask

   // reset for 20 cycles, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      cy(3);
      t_sleep_wake();
      t_master();
      t_slave();
      stop_test();
   end
endmodule
